/* design/psc_pkg.sv */
package psc_pkg;

	// ==========================================================
	// field layout and widths
	// ==========================================================
	// request-command field width
	localparam int REQ_CMD_W = 5;
	// request-command value driven while idle (active low, all inactive)
	localparam logic [4:0] REQ_CMD_IDLE = 5'h1F;

	// ==========================================================
	// timing
	// ==========================================================
	// clock rate in kHz and period in ns
	localparam int CLK_KHZ = 20000;
	localparam int CLK_PERIOD_NS = 50;
	// least time power-good must stay high before boot is allowed, in ns
	localparam int PG_SETTLE_NS = 1000;
	// same time in clock cycles, rounded up (20 cycles)
	localparam int PG_SETTLE_CYC = (PG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// width of the power-good settle counter
	localparam int PG_CNT_W = 6;

	// ==========================================================
	// machine-check configuration bit positions
	// ==========================================================
	localparam int MCK_EN_BIT = 0;	// global enable
	localparam int MCK_INT_BIT = 1;	// assert on internal error
	localparam int MCK_INIT_BIT = 2;	// assert as initiator on observed error
	localparam int MCK_CFG_W = 3;

	// ==========================================================
	// carriers
	// ==========================================================
	// machine-check configuration word
	typedef struct packed {
		logic initErr;	// assert as initiator after observed error
		logic intErr;	// assert on internal error
		logic enable;	// global enable
	} psc_mck_cfg_t;

	// error events from the core, one-cycle pulses, same clock
	typedef struct packed {
		logic internalErr;	// internal fault detected
		logic initiatorErr;	// error seen in a transaction we started
		logic observedErr;	// error seen in any bus transaction
	} psc_err_evt_t;

	// bus-side request from the core
	typedef struct packed {
		logic       valid;	// a transaction starts this cycle
		logic       locked;	// part of a locked sequence
		logic       lastLocked;	// final transaction of the locked sequence
		logic [4:0] cmd;	// transaction type, active high
	} psc_req_t;

	// sequencing states
	typedef enum logic [1:0] {
		PSC_OFF,
		PSC_SETTLE,
		PSC_RUN,
		PSC_HALT
	} psc_state_t;

endpackage

/* design/psc_sideband.sv */
`timescale 1ns/10ps
// What this block does
// - Shared machine-check line, any agent drives
// - Machine-check conditions configurable, incl. enable
// - Internal error drives machine-check with internal-error
// - Initiator asserts machine-check after observed error
// - Any observed bus error asserts machine-check
// - Boot only with second strap low
// - Newer configuration needs first strap low
// - Drive thermal alarm when sensor hits maximum
// - External alarm activates thermal control circuit
// - Circuit stays active until alarm released
// - Owner drives five-bit request command field
// - Internal error held until next reset
// - Lock held from first locked command, released as the last one launches
module psc_sideband (
	input  wire logic                    mclk,
	input  wire logic                    nrst,
	// configuration and status from the core, same clock
	input  wire psc_pkg::psc_mck_cfg_t   mckCfg,
	input  wire psc_pkg::psc_err_evt_t   errEvt,
	input  wire logic                    newerRegCfg,
	input  wire logic                    tccEnable,
	input  wire logic                    sensorAtMax,
	input  wire logic                    ownsBus,
	input  wire psc_pkg::psc_req_t       coreReq,
	// pins from outside
	input  wire logic                    power_good_in,
	input  wire logic [1:0]              platform_support_straps,
	input  wire logic                    machine_check_error_n_in,
	input  wire logic                    thermal_alarm_n_in,
	input  wire logic                    priority_bus_request_n,
	input  wire logic                    lock_n_in,
	// pins to outside
	output logic                         machine_check_error_n_out,
	output logic                         machine_check_error_n_oe,
	output logic                         thermal_alarm_n_out,
	output logic                         thermal_alarm_n_oe,
	output logic                         internal_error_n,
	output logic                         lock_n_out,
	output logic                         lock_n_oe,
	output logic [4:0]                   request_cmd_n,
	output logic                         request_cmd_oe,
	output logic                         address_strobe_first_n,
	// status to the core
	output logic                         bootAllowed,
	output logic                         bootRefused,
	output logic                         tccActive,
	output logic                         mckSeen,
	output logic                         priorityHeld
);

	// ==========================================================
	// reset release
	// ==========================================================
	// reset released through two flops, asserted at once
	logic [1:0] rstSync_reg;
	logic       rstN;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rstSync_reg <= 2'h0;
		end else begin
			rstSync_reg <= {rstSync_reg[0], 1'b1};
		end
	end
	assign rstN = rstSync_reg[1];

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	// six asynchronous pins, each through two flops
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] pinRaw;
	logic [NSYNC-1:0] syncA_reg;	// first stage, read only by second stage
	logic [NSYNC-1:0] syncB_reg;	// usable copy
	logic             pgS;
	logic [1:0]       strapS;
	logic             mckInS;
	logic             alarmInS;
	logic             lockInS;

	localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h3E;	// idle levels, so no false event after reset
	assign pinRaw = {lock_n_in, thermal_alarm_n_in, machine_check_error_n_in,
		platform_support_straps, power_good_in};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : gSync
			always_ff @(posedge mclk or negedge rstN) begin
				if (!rstN) begin
					syncA_reg[gi] <= SYNC_IDLE[gi];
					syncB_reg[gi] <= SYNC_IDLE[gi];
				end else begin
					syncA_reg[gi] <= pinRaw[gi];
					syncB_reg[gi] <= syncA_reg[gi];
				end
			end
		end
	endgenerate

	assign pgS      = syncB_reg[0];
	assign strapS   = syncB_reg[2:1];
	assign mckInS   = syncB_reg[3];
	assign alarmInS = syncB_reg[4];
	assign lockInS  = syncB_reg[5];

	// ==========================================================
	// boot gating from power-good and straps
	// ==========================================================
	// strap check shared by the state machine and the refusal flag
	function automatic logic strapsOk(input logic [1:0] s, input logic newer);
		// first strap only for newer part
		strapsOk = !s[1] && (!newer || !s[0]);
	endfunction

	psc_pkg::psc_state_t state_reg, state_next;
	logic [psc_pkg::PG_CNT_W-1:0] pgCnt_reg, pgCnt_next;
	logic bootRefused_reg, bootRefused_next;
	logic bootAllowed_reg, bootAllowed_next;	// kept in a flop so the output is registered

	// power-good must stay high for the settle time before boot
	always_comb begin
		state_next = state_reg;
		pgCnt_next = pgCnt_reg;
		bootRefused_next = bootRefused_reg;
		unique case (state_reg)
			psc_pkg::PSC_OFF: begin
				pgCnt_next = '0;
				if (pgS) begin
					state_next = psc_pkg::PSC_SETTLE;
				end
			end
			psc_pkg::PSC_SETTLE: begin
				if (!pgS) begin
					state_next = psc_pkg::PSC_OFF;
				end else if (pgCnt_reg == psc_pkg::PG_CNT_W'(psc_pkg::PG_SETTLE_CYC - 1)) begin
					// straps judged once power is settled
					if (strapsOk(strapS, newerRegCfg)) begin
						state_next = psc_pkg::PSC_RUN;
						bootRefused_next = 1'b0;
					end else begin
						state_next = psc_pkg::PSC_HALT;
						bootRefused_next = 1'b1;
					end
				end else begin
					pgCnt_next = pgCnt_reg + 1'b1;
				end
			end
			psc_pkg::PSC_RUN, psc_pkg::PSC_HALT: begin
				if (!pgS) begin
					state_next = psc_pkg::PSC_OFF;
				end
			end
		endcase
		bootAllowed_next = (state_next == psc_pkg::PSC_RUN);
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			state_reg       <= psc_pkg::PSC_OFF;
			pgCnt_reg       <= '0;
			bootRefused_reg <= 1'b0;
			bootAllowed_reg <= 1'b0;
		end else begin
			state_reg       <= state_next;
			pgCnt_reg       <= pgCnt_next;
			bootRefused_reg <= bootRefused_next;
			bootAllowed_reg <= bootAllowed_next;
		end
	end

	// ==========================================================
	// internal error and machine-check
	// ==========================================================
	logic ierrN_reg, ierrN_next;
	logic mckDrive_reg, mckDrive_next;
	logic mckSeen_reg, mckSeen_next;

	// machine-check drive is a level that follows this cycle's events
	always_comb begin
		ierrN_next = ierrN_reg & !errEvt.internalErr;
		mckDrive_next = 1'b0;
		if (mckCfg.enable) begin
			if (mckCfg.intErr && errEvt.internalErr) begin
				mckDrive_next = 1'b1;
			end
			if (mckCfg.initErr && errEvt.initiatorErr) begin
				mckDrive_next = 1'b1;
			end
			if (errEvt.observedErr) begin
				mckDrive_next = 1'b1;
			end
		end
		mckSeen_next = !mckInS;
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			ierrN_reg    <= 1'b1;
			mckDrive_reg <= 1'b0;
			mckSeen_reg  <= 1'b0;
		end else begin
			ierrN_reg    <= ierrN_next;
			mckDrive_reg <= mckDrive_next;
			mckSeen_reg  <= mckSeen_next;
		end
	end

	// ==========================================================
	// thermal alarm and control circuit
	// ==========================================================
	logic alarmDrive_reg, alarmDrive_next;
	logic tcc_reg, tcc_next;
	logic [1:0] drvDly_reg, drvDly_next;	// own drive aged to match the pin synchroniser

	// the aged copy masks the echo of our own drive that the synchroniser still shows
	always_comb begin
		alarmDrive_next = sensorAtMax;
		drvDly_next = {drvDly_reg[0], alarmDrive_reg};
		tcc_next = 1'b0;
		if (tccEnable) begin
			tcc_next = sensorAtMax || (!alarmInS && !drvDly_reg[1]);
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			alarmDrive_reg <= 1'b0;
			tcc_reg        <= 1'b0;
			drvDly_reg     <= 2'h0;
		end else begin
			alarmDrive_reg <= alarmDrive_next;
			tcc_reg        <= tcc_next;
			drvDly_reg     <= drvDly_next;
		end
	end

	// ==========================================================
	// request command, lock and priority hold-off
	// ==========================================================
	logic       lock_reg, lock_next;
	logic       reqOe_reg, reqOe_next;
	logic [4:0] reqN_reg, reqN_next;
	logic       strobeN_reg, strobeN_next;
	logic       prioHeld_reg, prioHeld_next;
	logic       prioS_reg;

	// priority request is a pin; sample it twice too
	logic prioA_reg;
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			prioA_reg <= 1'b1;
			prioS_reg <= 1'b1;
		end else begin
			prioA_reg <= priority_bus_request_n;
			prioS_reg <= prioA_reg;
		end
	end

	// command and strobe are launched together from one edge
	always_comb begin
		lock_next = lock_reg;
		reqOe_next = 1'b0;
		reqN_next = psc_pkg::REQ_CMD_IDLE;
		strobeN_next = 1'b1;
		if (ownsBus && coreReq.valid && state_reg == psc_pkg::PSC_RUN) begin
			reqOe_next = 1'b1;
			reqN_next = ~coreReq.cmd;
			strobeN_next = 1'b0;
			if (coreReq.locked) begin
				lock_next = !coreReq.lastLocked;
			end
		end
		if (!ownsBus) begin
			lock_next = 1'b0;
		end
		prioHeld_next = !prioS_reg && (lock_next || !lockInS);
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			lock_reg     <= 1'b0;
			reqOe_reg    <= 1'b0;
			reqN_reg     <= psc_pkg::REQ_CMD_IDLE;
			strobeN_reg  <= 1'b1;
			prioHeld_reg <= 1'b0;
		end else begin
			lock_reg     <= lock_next;
			reqOe_reg    <= reqOe_next;
			reqN_reg     <= reqN_next;
			strobeN_reg  <= strobeN_next;
			prioHeld_reg <= prioHeld_next;
		end
	end

	// ==========================================================
	// outputs, straight from flops except the three pin levels tied low
	// ==========================================================
	// open-drain style: drive low while enabled
	assign machine_check_error_n_out = 1'b0;
	assign machine_check_error_n_oe  = mckDrive_reg;
	assign thermal_alarm_n_out       = 1'b0;
	assign thermal_alarm_n_oe        = alarmDrive_reg;
	assign internal_error_n          = ierrN_reg;
	assign lock_n_out                = 1'b0;
	assign lock_n_oe                 = lock_reg;
	assign request_cmd_n             = reqN_reg;
	assign request_cmd_oe            = reqOe_reg;
	assign address_strobe_first_n    = strobeN_reg;
	assign bootAllowed               = bootAllowed_reg;
	assign bootRefused               = bootRefused_reg;
	assign tccActive                 = tcc_reg;
	assign mckSeen                   = mckSeen_reg;
	assign priorityHeld              = prioHeld_reg;

endmodule

/* tb/psc_sideband_sva.sv */
`timescale 1ns/10ps
module psc_sideband_sva (
	input wire logic                  mclk,
	input wire logic                  nrst,
	input wire psc_pkg::psc_mck_cfg_t mckCfg,
	input wire psc_pkg::psc_err_evt_t errEvt,
	input wire logic                  newerRegCfg,
	input wire logic                  tccEnable,
	input wire logic                  sensorAtMax,
	input wire logic                  ownsBus,
	input wire psc_pkg::psc_req_t     coreReq,
	input wire logic [1:0]            platform_support_straps,
	input wire logic                  thermal_alarm_n_in,
	input wire logic                  machine_check_error_n_oe,
	input wire logic                  thermal_alarm_n_oe,
	input wire logic                  internal_error_n,
	input wire logic                  lock_n_oe,
	input wire logic [4:0]            request_cmd_n,
	input wire logic                  request_cmd_oe,
	input wire logic                  address_strobe_first_n,
	input wire logic                  bootAllowed,
	input wire logic                  tccActive
);
	// ==========================================================
	// properties on the block's outputs
	// ==========================================================
	// one clock domain, so clock and reset are given once
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	AST_INTERNAL_ERROR_N_SET: assert property (errEvt.internalErr |=> !internal_error_n)
		else $error("internal error not flagged");
	AST_INTERNAL_ERROR_N_HOLD: assert property (!internal_error_n |=> !internal_error_n)
		else $error("internal error released");
	AST_MCK_OFF: assert property (machine_check_error_n_oe |-> $past(mckCfg.enable))
		else $error("machine check driven while disabled");
	AST_MCK_INT: assert property (errEvt.internalErr && mckCfg.intErr && mckCfg.enable
		|=> machine_check_error_n_oe) else $error("no machine check on internal error");
	AST_MCK_INIT: assert property (errEvt.initiatorErr && mckCfg.initErr && mckCfg.enable
		|=> machine_check_error_n_oe) else $error("no machine check as initiator");
	AST_MCK_OBS: assert property (errEvt.observedErr && mckCfg.enable
		|=> machine_check_error_n_oe) else $error("no machine check on observed error");
	AST_HOT_OUT: assert property (sensorAtMax |=> thermal_alarm_n_oe)
		else $error("thermal alarm not driven");
	AST_TCC_EXT: assert property ((tccEnable && !thermal_alarm_n_in
		&& !thermal_alarm_n_oe)[*4] |=> tccActive)
		else $error("thermal control not active under alarm");
	AST_BOOT: assert property ($rose(bootAllowed) |-> !platform_support_straps[1]
		&& !(newerRegCfg && platform_support_straps[0])) else $error("boot with bad straps");
	AST_CMD: assert property (ownsBus && coreReq.valid && bootAllowed |=> request_cmd_oe
		&& !address_strobe_first_n && request_cmd_n == ~$past(coreReq.cmd))
		else $error("request command wrong");
	AST_LOCK: assert property (lock_n_oe && ownsBus && !coreReq.lastLocked |=> lock_n_oe)
		else $error("lock dropped inside sequence");
endmodule

bind psc_sideband psc_sideband_sva psc_sideband_sva_inst (.*);

/* tb/psc_fsb_agent.sv */
`timescale 1ns/10ps
module psc_fsb_agent (
	input  wire logic mclk,
	input  wire logic mckOe,
	input  wire logic hotOe,
	input  wire logic lockOe,
	input  wire logic wantPrio,
	input  wire logic extMck,
	input  wire logic extHot,
	output logic      mckLine,
	output logic      hotLine,
	output logic      lockLine,
	output logic      prioReqN,
	output logic      prioOwner
);
	// ==========================================================
	// shared lines, pulled up whenever nobody pulls them low
	// ==========================================================
	// any agent pulls low
	assign mckLine = !(mckOe || extMck);
	assign hotLine = !(hotOe || extHot);
	assign lockLine = !lockOe;
	assign prioReqN = !wantPrio;
	always_ff @(posedge mclk) prioOwner <= wantPrio && lockLine;
endmodule

/* tb/psc_sideband_test.sv */
`timescale 1ns/10ps
module psc_sideband_test;
	// ==========================================================
	// stimulus, wires and bookkeeping
	// ==========================================================
	logic mclk, nrst, newer, tccEn, atMax, owns, pg, wantPrio, extMck, extHot, e;
	logic mckOe, hotOe, lockOe, mckLine, hotLine, lockLine, prioN, prioOwner;
	logic cmdOe, strobeN, ierrN, bootOk, bootNo, tccOn, mckSeen, held;
	logic mckOut, hotOut, lockOut;	// levels put on the shared lines while enabled
	logic [1:0] straps;
	logic [4:0] cmdN;
	logic [31:0] seed = 32'h21E4C3D5;
	logic [4:0] expQ[$];	// expected request command levels
	psc_pkg::psc_mck_cfg_t cfg;
	psc_pkg::psc_err_evt_t evt;
	psc_pkg::psc_req_t req;
	int errors, compares, cyc;
	psc_sideband psc_sideband_inst (.mclk(mclk), .nrst(nrst), .mckCfg(cfg), .errEvt(evt),
		.newerRegCfg(newer), .tccEnable(tccEn), .sensorAtMax(atMax), .ownsBus(owns),
		.coreReq(req), .power_good_in(pg), .platform_support_straps(straps),
		.machine_check_error_n_in(mckLine), .thermal_alarm_n_in(hotLine),
		.priority_bus_request_n(prioN), .lock_n_in(lockLine),
		.machine_check_error_n_out(mckOut), .machine_check_error_n_oe(mckOe),
		.thermal_alarm_n_out(hotOut), .thermal_alarm_n_oe(hotOe), .internal_error_n(ierrN),
		.lock_n_out(lockOut), .lock_n_oe(lockOe), .request_cmd_n(cmdN), .request_cmd_oe(cmdOe),
		.address_strobe_first_n(strobeN), .bootAllowed(bootOk), .bootRefused(bootNo),
		.tccActive(tccOn), .mckSeen(mckSeen), .priorityHeld(held));
	psc_fsb_agent psc_fsb_agent_inst (.mclk(mclk), .mckOe(mckOe), .hotOe(hotOe),
		.lockOe(lockOe), .wantPrio(wantPrio), .extMck(extMck), .extHot(extHot),
		.mckLine(mckLine), .hotLine(hotLine), .lockLine(lockLine), .prioReqN(prioN),
		.prioOwner(prioOwner));
	// ==========================================================
	// helpers
	// ==========================================================
	task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// inputs always move 2 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic test_done;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// power-good cycle; straps only move while power-good is low
	task automatic boot(input logic [1:0] s, input logic n, input logic ok);
		pg = 0;
		tick(5);
		straps = s;
		newer = n;
		pg = 1;
		tick(30);
		check("boot", 5'(bootOk), 5'(ok));
		check("refuse", 5'(bootNo), 5'(!ok));
	endtask
	// ==========================================================
	// clock, timeout and command monitor
	// ==========================================================
	initial begin
		mclk = 0;
		forever #25 mclk = !mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end
	// every command cycle must match the oldest note
	always @(negedge mclk) begin
		if (cmdOe === 1'b1) begin
			if (expQ.size() == 0) check("extra", 5'h01, 5'h00);
			else check("cmd", cmdN, expQ.pop_front());
			check("strobe", 5'(strobeN), 5'h00);
		end
	end
	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		{nrst, tccEn, atMax, owns, pg, wantPrio, extMck, extHot, straps} = '0;
		newer = 1;
		cfg = '0;
		evt = '0;
		req = '0;
		tick(20);
		nrst = 1;
		tick(3);
		boot(2'h2, 1'b0, 1'b0);
		boot(2'h1, 1'b1, 1'b0);
		boot(2'h1, 1'b0, 1'b1);
		boot(2'h0, 1'b1, 1'b1);
		// power-good stays high from here on
		// back-to-back random commands, then one without ownership
		owns = 1;
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			req = '{1'b1, 1'b0, 1'b0, seed[4:0]};
			expQ.push_back(~seed[4:0]);
			tick(1);
		end
		owns = 0;
		tick(1);
		owns = 1;
		// locked pair with the priority agent waiting on it
		wantPrio = 1;
		req = '{1'b1, 1'b1, 1'b0, 5'h0A};
		expQ.push_back(5'h15);
		tick(1);
		req = '0;
		tick(4);
		check("lock", 5'(lockOe), 5'h01);
		check("held", 5'(held), 5'h01);
		check("prio", 5'(prioOwner), 5'h00);
		check("pinsLow", 5'({mckOut, hotOut, lockOut}), 5'h00);
		req = '{1'b1, 1'b1, 1'b1, 5'h0B};
		expQ.push_back(5'h14);
		tick(1);
		req = '0;
		tick(5);
		check("unlock", 5'(lockOe), 5'h00);
		check("free", 5'(held), 5'h00);
		check("left", 5'(expQ.size()), 5'h00);
		wantPrio = 0;
		// every configuration against every error kind
		for (int c = 0; c < 8; c++) begin
			for (int k = 0; k < 3; k++) begin
				cfg = c[2:0];
				evt = 3'(1 << k);
				e = c[0] && (k == 0 || (k == 1 && c[2]) || (k == 2 && c[1]));
				tick(1);
				evt = '0;
				check("mck", 5'(mckOe), 5'(e));
				tick(1);
			end
		end
		tick(4);
		check("internal_error_n", 5'(ierrN), 5'h00);
		// thermal alarm out and in
		tccEn = 1;
		atMax = 1;
		tick(2);
		check("hotOe", 5'(hotOe), 5'h01);
		check("tcc", 5'(tccOn), 5'h01);
		atMax = 0;
		tick(3);
		extHot = 1;
		extMck = 1;
		tick(10);
		check("tccExt", 5'(tccOn), 5'h01);
		check("mckSeen", 5'(mckSeen), 5'h01);
		extHot = 0;
		extMck = 0;
		tick(4);
		check("tccOff", 5'(tccOn), 5'h00);
		tccEn = 0;
		extHot = 1;
		tick(4);
		check("tccDis", 5'(tccOn), 5'h00);
		extHot = 0;
		// a new reset clears the sticky error
		nrst = 0;
		tick(2);
		nrst = 1;
		tick(3);
		check("ierrRst", 5'(ierrN), 5'h01);
		test_done();
	end
endmodule
